/* logic/bzw_pkg.sv */
package bzw_pkg;
	// register indexes; byte address on the bus is four times the index
	localparam logic [15:0] BZW_IDX_BIF    = 16'hF900; // bus_interface_config
	localparam logic [15:0] BZW_IDX_IOZ    = 16'hF902; // io_zone_timing_config
	localparam logic [15:0] BZW_IDX_ZONE0  = 16'hF904; // zone0_timing_config
	localparam logic [15:0] BZW_IDX_STATUS = 16'hF906; // cycle state, read only
	// values after reset
	localparam logic [15:0] BZW_RST_ZCFG   = 16'h069F;
	localparam logic [15:0] BZW_RST_BIF    = 16'h0007;
	// writable bits and bits that read as a fixed one
	localparam logic [15:0] BZW_MASK_IOZ   = 16'h029F;
	localparam logic [15:0] BZW_FIXED_IOZ  = 16'h0400;
	localparam logic [15:0] BZW_MASK_ZONE0 = 16'h0EFF;
	localparam logic [15:0] BZW_MASK_BIF   = 16'h0007;
	// field positions inside a zone configuration word; the early write bit sits in the bus interface word
	localparam int BZW_POS_WAIT = 0;
	localparam int BZW_POS_HOLD = 3;
	localparam int BZW_POS_BW   = 7;
	localparam int BZW_POS_POST = 9;
	localparam int BZW_POS_PRE  = 10;
	localparam int BZW_POS_FAST = 11;
	localparam int BZW_POS_EWR  = 0;
	// address windows of the zones
	localparam logic [15:0] BZW_FLASH_HI = 16'hBFFF;
	localparam logic [15:0] BZW_RAM_LO   = 16'hE000;
	localparam logic [15:0] BZW_RAM_HI   = 16'hE7FF;
	localparam logic [15:0] BZW_EE_LO    = 16'hF000;
	localparam logic [15:0] BZW_EE_HI    = 16'hF27F;
	localparam logic [15:0] BZW_CORE_LO  = 16'hF000;
	localparam logic [7:0]  BZW_IOP_PAGE = 8'hFB;
	// ahb transfer type
	localparam logic [1:0]  BZW_HTRANS_NONSEQ = 2'h2;

	typedef enum logic [2:0] {
		BZW_Z_FLASH = 3'h0,
		BZW_Z_RAM   = 3'h1,
		BZW_Z_EE    = 3'h2,
		BZW_Z_CORE  = 3'h3,
		BZW_Z_IOP   = 3'h4,
		BZW_Z_NONE  = 3'h5
	} bzw_zone_type;

	// gray codes along idle, gap, address, wait, data, hold
	typedef enum logic [2:0] {
		BZW_S_IDLE = 3'b000,
		BZW_S_GAP  = 3'b001,
		BZW_S_ADDR = 3'b011,
		BZW_S_WAIT = 3'b010,
		BZW_S_DATA = 3'b110,
		BZW_S_HOLD = 3'b111
	} bzw_state_type;

	// cpu core request, held until ack
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [15:0] addr;
	} bzw_req_type;

	// cycle control towards memories and peripherals
	typedef struct packed {
		bzw_state_type phase;
		bzw_zone_type  zone;
		logic          write;
		logic          width16;
		logic [15:0]   addr;
	} bzw_mem_type;
endpackage

/* logic/bzw_zone_timing.sv */
`timescale 1ns/100ps
// Operation
// - io zone config word at F902, reset 069F
// - zone-0 config word at F904, reset 069F
// - wait field adds zero to seven waits
// - hold field adds zero to three holds
// - fast read ignores zone-0 wait and hold
// - width bit: 0 eight bit, 1 sixteen
// - post idle before next different-zone cycle
// - zone-0 pre idle before new-zone cycle
// - fast read single clock, else two clocks
// - fast flash read: no waits, no holds
// - normal flash read: 1+wait waits, holds
// - fast-mode flash write: 1+early-write waits, no hold
// - normal flash write: wait+1 or +2, holds
// - static ram: no waits, no holds
// - eeprom: fast bit picks 0 or 1 wait
// - core and peripherals: one wait, no hold
// - port zone timed by io zone config
// - bit 0 selects late or early write
// - waits after address, holds at end
module bzw_zone_timing (
	input  wire logic                 core_clk,
	input  wire logic                 nrst,
	input  wire logic                 ce,
	// ahb-lite register port
	input  wire logic                 hsel,
	input  wire logic [17:0]          haddr,
	input  wire logic [1:0]           htrans,
	input  wire logic                 hwrite,
	input  wire logic [2:0]           hsize,
	input  wire logic [31:0]          hwdata,
	input  wire logic                 hready,
	output logic                      hreadyout,
	output logic                      hresp,
	output logic [31:0]               hrdata,
	// cpu core side
	input  wire bzw_pkg::bzw_req_type req,
	output logic                      ack,
	// memory side
	input  wire logic                 eeprom_fast_access,
	output bzw_pkg::bzw_mem_type      mem
);
	import bzw_pkg::*;

	// configuration registers
	logic [15:0]   ioz_reg;            // io zone timing word
	logic [15:0]   ioz_next;
	logic [15:0]   zone0_reg;          // flash zone timing word
	logic [15:0]   zone0_next;
	logic [15:0]   bif_reg;            // bus interface word, low bits used
	logic [15:0]   bif_next;
	// ahb data phase bookkeeping
	logic          wr_pend_reg;        // a write data phase is due
	logic [15:0]   wr_idx_reg;         // its register index
	logic [31:0]   hrdata_reg;
	// cycle engine
	bzw_state_type state_reg;
	bzw_state_type state_next;
	// four bits: an early write with seven extra waits runs nine wait clocks
	logic [3:0]    cnt_reg;            // remaining waits or holds minus one
	logic [3:0]    cnt_next;
	bzw_zone_type  zone_reg;
	logic          write_reg;
	logic [15:0]   addr_reg;
	logic          width_reg;
	logic          fast_reg;           // single-clock read of this cycle
	logic [3:0]    waits_reg;
	logic [1:0]    holds_reg;
	logic          post_reg;           // post idle armed by the current zone
	bzw_zone_type  prev_zone_reg;
	logic          prev_post_reg;
	logic          have_prev_reg;      // no gap before the very first cycle
	logic          ack_reg;

	// map an address onto its zone; the port page wins over the core range
	function automatic bzw_zone_type zone_of(input logic [15:0] a);
		if (a[15:8] == BZW_IOP_PAGE) begin
			return BZW_Z_IOP;
		end else if (a >= BZW_EE_LO && a <= BZW_EE_HI) begin
			return BZW_Z_EE;
		end else if (a >= BZW_CORE_LO) begin
			return BZW_Z_CORE;
		end else if (a >= BZW_RAM_LO && a <= BZW_RAM_HI) begin
			return BZW_Z_RAM;
		end else if (a <= BZW_FLASH_HI) begin
			return BZW_Z_FLASH;
		end
		return BZW_Z_NONE;
	endfunction

	// wait cycles of an access
	function automatic logic [3:0] waits_of(input bzw_zone_type z, input logic wr,
			input logic [15:0] z0, input logic [15:0] io, input logic early_write_select,
			input logic eef);
		logic [3:0] w0;
		logic [3:0] wi;
		w0 = {1'b0, z0[BZW_POS_WAIT +: 3]};
		wi = {1'b0, io[BZW_POS_WAIT +: 3]};
		unique case (z)
			BZW_Z_FLASH: begin
				if (z0[BZW_POS_FAST]) begin
					return wr ? 4'(1 + early_write_select) : 4'h0;
				end
				return wr ? 4'(w0 + 1 + early_write_select) : 4'(w0 + 1);
			end
			BZW_Z_RAM:  return 4'h0;
			BZW_Z_EE:   return eef ? 4'h0 : 4'h1;
			BZW_Z_CORE: return 4'h1;
			BZW_Z_IOP:  return 4'(wi + 1 + (wr & early_write_select));
			default:    return 4'h0;                  // unmapped space, no stretch
		endcase
	endfunction

	// hold cycles of an access; only flash and port zone ever hold
	function automatic logic [1:0] holds_of(input bzw_zone_type z,
			input logic [15:0] z0, input logic [15:0] io);
		if (z == BZW_Z_FLASH) begin
			return z0[BZW_POS_FAST] ? 2'h0 : z0[BZW_POS_HOLD +: 2];
		end
		if (z == BZW_Z_IOP) begin
			return io[BZW_POS_HOLD +: 2];
		end
		return 2'h0;
	endfunction

	// ---------------- register port ----------------
	wire        addr_phase = hsel & hready & (htrans == BZW_HTRANS_NONSEQ);
	wire [15:0] a_idx      = haddr[17:2];
	wire        wr_ioz     = wr_pend_reg & (wr_idx_reg == BZW_IDX_IOZ);
	wire        wr_zone0   = wr_pend_reg & (wr_idx_reg == BZW_IDX_ZONE0);
	wire        wr_bif     = wr_pend_reg & (wr_idx_reg == BZW_IDX_BIF);
	wire [15:0] wdat       = hwdata[15:0];

	// masked write; reserved bits are cleared, the fixed io zone bit is forced to one
	assign ioz_next   = wr_ioz   ? ((wdat & BZW_MASK_IOZ) | BZW_FIXED_IOZ) : ioz_reg;
	assign zone0_next = wr_zone0 ? (wdat & BZW_MASK_ZONE0) : zone0_reg;
	assign bif_next   = wr_bif   ? (wdat & BZW_MASK_BIF) : bif_reg;

	// read mux uses next values so a read right behind a write sees it
	wire [15:0] status_word = {7'h00, have_prev_reg, 2'h0, zone_reg, state_reg};
	wire [15:0] rd_word =
		(a_idx == BZW_IDX_IOZ)    ? ioz_next   :
		(a_idx == BZW_IDX_ZONE0)  ? zone0_next :
		(a_idx == BZW_IDX_BIF)    ? bif_next   :
		(a_idx == BZW_IDX_STATUS) ? status_word : 16'h0000;

	// zero-wait slave; hsize is not checked since only words are used
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			ioz_reg     <= BZW_RST_ZCFG;
			zone0_reg   <= BZW_RST_ZCFG;
			bif_reg     <= BZW_RST_BIF;
			wr_pend_reg <= 1'b0;
			wr_idx_reg  <= 16'h0000;
			hrdata_reg  <= 32'h0000_0000;
		end else if (ce) begin
			ioz_reg     <= ioz_next;
			zone0_reg   <= zone0_next;
			bif_reg     <= bif_next;
			wr_pend_reg <= addr_phase & hwrite;
			wr_idx_reg  <= a_idx;
			if (addr_phase & !hwrite) begin
				hrdata_reg <= {16'h0000, rd_word};
			end
		end
	end

	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_reg;

	// ---------------- cycle engine ----------------
	// a request is only taken once the previous ack has gone
	wire          start     = req.valid & !ack_reg;
	bzw_zone_type new_zone;
	assign new_zone = zone_of(req.addr);
	wire          zone_chg  = have_prev_reg & (new_zone != prev_zone_reg);
	wire          pre_req   = (new_zone == BZW_Z_FLASH) & zone0_reg[BZW_POS_PRE];
	// one idle clock covers both the post and the pre gap
	wire          need_gap  = zone_chg & (prev_post_reg | pre_req);
	// snapshot of the timing, taken when the cycle is accepted
	wire [3:0]    new_waits = waits_of(new_zone, req.write, zone0_reg, ioz_reg,
		bif_reg[BZW_POS_EWR], eeprom_fast_access);
	wire [1:0]    new_holds = holds_of(new_zone, zone0_reg, ioz_reg);
	wire          new_fast  = (new_zone == BZW_Z_FLASH) & !req.write
		& zone0_reg[BZW_POS_FAST];
	wire          new_width = (new_zone == BZW_Z_IOP) ? ioz_reg[BZW_POS_BW]
		: zone0_reg[BZW_POS_BW];
	wire          new_post  = (new_zone == BZW_Z_IOP) ? ioz_reg[BZW_POS_POST]
		: zone0_reg[BZW_POS_POST];
	wire          leave_cyc = (state_next == BZW_S_IDLE) & (state_reg != BZW_S_IDLE)
		& (state_reg != BZW_S_GAP);

	// next state: address, then waits, then data, then holds
	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		unique case (state_reg)
			BZW_S_IDLE: begin
				if (start) begin
					state_next = need_gap ? BZW_S_GAP : BZW_S_ADDR;
				end
			end
			BZW_S_GAP: begin
				state_next = BZW_S_ADDR;
			end
			BZW_S_ADDR: begin
				// waits follow the address straight away
				if (waits_reg != 4'h0) begin
					state_next = BZW_S_WAIT;
					cnt_next   = waits_reg - 4'h1;
				end else if (fast_reg) begin
					state_next = BZW_S_IDLE;
				end else begin
					state_next = BZW_S_DATA;
				end
			end
			BZW_S_WAIT: begin
				if (cnt_reg == 4'h0) begin
					state_next = BZW_S_DATA;
				end else begin
					cnt_next = cnt_reg - 4'h1;
				end
			end
			BZW_S_DATA: begin
				// holds stretch the end with data kept on the bus
				if (holds_reg != 2'h0) begin
					state_next = BZW_S_HOLD;
					cnt_next   = {2'b00, holds_reg} - 4'h1;
				end else begin
					state_next = BZW_S_IDLE;
				end
			end
			BZW_S_HOLD: begin
				if (cnt_reg == 4'h0) begin
					state_next = BZW_S_IDLE;
				end else begin
					cnt_next = cnt_reg - 4'h1;
				end
			end
		endcase
	end

	// cycle state and snapshot of its timing
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			state_reg     <= BZW_S_IDLE;
			cnt_reg       <= 4'h0;
			zone_reg      <= BZW_Z_NONE;
			write_reg     <= 1'b0;
			addr_reg      <= 16'h0000;
			width_reg     <= 1'b1;
			fast_reg      <= 1'b0;
			waits_reg     <= 4'h0;
			holds_reg     <= 2'h0;
			post_reg      <= 1'b0;
			prev_zone_reg <= BZW_Z_NONE;
			prev_post_reg <= 1'b0;
			have_prev_reg <= 1'b0;
			ack_reg       <= 1'b0;
		end else if (ce) begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			ack_reg   <= leave_cyc;
			// config is frozen per cycle, so a register write only counts
			// for cycles accepted after its data phase
			if (state_reg == BZW_S_IDLE && start) begin
				zone_reg  <= new_zone;
				write_reg <= req.write;
				addr_reg  <= req.addr;
				width_reg <= new_width;
				fast_reg  <= new_fast;
				waits_reg <= new_waits;
				holds_reg <= new_holds;
				post_reg  <= new_post;
			end
			// remember the finished cycle for the next zone compare
			if (leave_cyc) begin
				prev_zone_reg <= zone_reg;
				prev_post_reg <= post_reg;
				have_prev_reg <= 1'b1;
			end
		end
	end

	assign ack         = ack_reg;
	assign mem.phase   = state_reg;
	assign mem.zone    = zone_reg;
	assign mem.write   = write_reg;
	assign mem.width16 = width_reg;
	assign mem.addr    = addr_reg;
endmodule

/* test/bzw_cpu_model.sv */
`timescale 1ns/100ps
// cpu core: holds each request until ack, may idle between requests
module bzw_cpu_model (
	input  wire logic                 core_clk,
	output bzw_pkg::bzw_req_type      req,
	input  wire logic                 ack,
	input  wire bzw_pkg::bzw_mem_type mem
);
	import bzw_pkg::*;
	initial req = '{1'b0, 1'b0, 16'h0000};
	// one access; returns clocks until ack, and zone, width, direction and address
	// seen in the address phase
	task automatic access(input logic wr, input logic [15:0] a, input int gap,
		output int n, output logic [2:0] z, output logic w, output logic wo,
		output logic [15:0] ao);
		repeat (gap) @(posedge core_clk); // slow cpu
		req <= '{1'b1, wr, a};
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
			if (mem.phase == BZW_S_ADDR) begin
				z = mem.zone;
				w = mem.width16;
				wo = mem.write;
				ao = mem.addr;
			end
		end while (ack !== 1'b1 && n < 60);
		// released lines show the inverse, never the last value
		req <= '{1'b0, ~wr, ~a};
		@(posedge core_clk);
	endtask
endmodule

/* test/bzw_zone_timing_assertions.sv */
`timescale 1ns/100ps
// watches bus cycle sequencing at the top ports only
module bzw_zone_timing_chk (
	input wire logic                 core_clk,
	input wire logic                 nrst,
	input wire logic                 hreadyout,
	input wire logic                 hresp,
	input wire logic                 ack,
	input wire bzw_pkg::bzw_req_type req,
	input wire bzw_pkg::bzw_mem_type mem
);
	import bzw_pkg::*;
	// one domain, so clock and reset are given once
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);

	bus_okay_a: assert property (hreadyout && !hresp)
		else $error("register port stalled or errored");
	ack_single_a: assert property (ack |=> !ack)
		else $error("ack longer than one cycle");
	ack_end_a: assert property (ack |-> mem.phase == BZW_S_IDLE &&
		$past(mem.phase) inside {BZW_S_ADDR, BZW_S_DATA, BZW_S_HOLD})
		else $error("ack not right after cycle end");
	cycle_start_a: assert property (mem.phase == BZW_S_IDLE && !ack && req.valid
		|=> mem.phase inside {BZW_S_GAP, BZW_S_ADDR})
		else $error("request not started");
	gap_single_a: assert property (mem.phase == BZW_S_GAP |=> mem.phase == BZW_S_ADDR)
		else $error("idle gap not one clock");
	wait_order_a: assert property (mem.phase == BZW_S_WAIT
		|-> $past(mem.phase) inside {BZW_S_ADDR, BZW_S_WAIT})
		else $error("wait not after address");
	hold_order_a: assert property (mem.phase == BZW_S_HOLD
		|-> $past(mem.phase) inside {BZW_S_DATA, BZW_S_HOLD})
		else $error("hold not after data");
	hold_max_a: assert property ((mem.phase == BZW_S_HOLD)[*3] |=> mem.phase != BZW_S_HOLD)
		else $error("more than three holds");
	wait_max_a: assert property ((mem.phase == BZW_S_WAIT)[*8] ##1
		mem.phase == BZW_S_WAIT |=> mem.phase != BZW_S_WAIT)
		else $error("more than nine waits");
	ram_timing_a: assert property (mem.phase == BZW_S_ADDR && mem.zone == BZW_Z_RAM
		|=> mem.phase == BZW_S_DATA ##1 mem.phase == BZW_S_IDLE)
		else $error("ram cycle not zero wait");
	core_timing_a: assert property (mem.phase == BZW_S_ADDR && mem.zone == BZW_Z_CORE
		|=> mem.phase == BZW_S_WAIT ##1 mem.phase == BZW_S_DATA ##1 mem.phase == BZW_S_IDLE)
		else $error("core cycle not one wait");
	ram_decode_a: assert property (mem.phase == BZW_S_ADDR &&
		mem.addr inside {[16'hE000:16'hE7FF]} |-> mem.zone == BZW_Z_RAM)
		else $error("ram window misdecoded");
endmodule

bind bzw_zone_timing bzw_zone_timing_chk u_chk (.core_clk, .nrst, .hreadyout, .hresp, .ack,
	.req, .mem);

/* test/testbench.sv */
`timescale 1ns/100ps
module testbench;
	import bzw_pkg::*;
	logic               core_clk = 1'b0;
	logic               nrst = 1'b0;
	logic               ce = 1'b1;
	logic               hsel = 1'b1;
	logic [17:0]        haddr = 18'h00000;
	logic [1:0]         htrans = 2'h0;
	logic               hwrite = 1'b0;
	logic [2:0]         hsize = 3'h2;
	logic [31:0]        hwdata = 32'h00000000;
	logic               hreadyout, hresp, ack;
	logic               eeprom_fast_access = 1'b0;
	logic [31:0]        hrdata;
	bzw_req_type        req;
	bzw_mem_type        mem;
	int                 fail_count = 0;
	int                 comparisons = 0;
	int                 seed = 32'h79fd0039;
	int                 pz = -1; // previous zone, none after reset
	int                 pp = 0;  // post idle bit frozen with the previous cycle
	logic [31:0]        z0, io, bif; // shadow of the config words
	logic [15:0]        base [5] = '{16'h0000, 16'hE000, 16'hF000, 16'hF400, 16'hFB00};
	logic [15:0]        msk [5] = '{16'h7FFF, 16'h07FF, 16'h00FF, 16'h00FF, 16'h00FF};

	always #10 core_clk = ~core_clk;

	bzw_zone_timing u_dut (.core_clk, .nrst, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .req, .ack,
		.eeprom_fast_access, .mem);
	bzw_cpu_model u_cpu (.core_clk, .req, .ack, .mem);

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// single ahb-lite transfer, entered and left just after a rising edge
	task automatic ahb(input logic wr, input logic [15:0] idx, input logic [31:0] wd,
		output logic [31:0] rd);
		htrans <= BZW_HTRANS_NONSEQ;
		hwrite <= wr;
		haddr <= {idx, 2'b00};
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge core_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask

	// clocks from raising a request to seeing ack, gaps and phases from the rules
	function automatic int cycles(input int z, input logic wr);
		int w, h, d, g;
		w = 0;
		h = 0;
		d = 1;
		case (z)
			0: if (!wr && z0[11]) d = 0;
				else begin
					w = 1 + (wr ? bif[0] : 0) + (z0[11] ? 0 : z0[2:0]);
					h = z0[11] ? 0 : z0[4:3];
				end
			2: w = eeprom_fast_access ? 0 : 1;
			3: w = 1;
			4: begin
				w = 1 + io[2:0] + (wr ? bif[0] : 0);
				h = io[4:3];
			end
			default: w = 0;
		endcase
		g = (pz >= 0 && pz != z && (pp != 0 || (z == 0 && z0[10])));
		return g + w + d + h + 3;
	endfunction

	task automatic finish_test();
		if (fail_count == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	// cuts a hang short well past the expected run length
	initial begin
		#400000;
		fail_count++;
		finish_test();
	end

	initial begin
		int n, k;
		logic [2:0] z;
		logic w;
		logic wo;
		logic [15:0] a, ao;
		logic [31:0] rd, r;
		repeat (4) @(posedge core_clk);
		nrst <= 1'b1;
		ahb(0, BZW_IDX_BIF, 0, rd); chk("bif reset", rd, 32'h7);
		ahb(0, BZW_IDX_IOZ, 0, rd); chk("io reset", rd, 32'h069F);
		ahb(0, BZW_IDX_ZONE0, 0, rd); chk("zone0 reset", rd, 32'h069F);
		ahb(1, 16'hF90A, 32'hFFFF, rd);
		ahb(0, 16'hF90A, 0, rd); chk("unmapped", rd, 32'h0);
		// low clock enable freezes the port, so this write must not land
		ce <= 1'b0;
		ahb(1, BZW_IDX_ZONE0, 32'h0000_0000, rd);
		ce <= 1'b1;
		ahb(0, BZW_IDX_ZONE0, 0, rd);
		chk("frozen", rd, 32'h0000_069F);
		// longest wait run: early write with seven extra waits, nine in all
		z0 = 32'h0000_0007;
		io = 32'h0000_0400;
		bif = 32'h0000_0007;
		ahb(1, BZW_IDX_ZONE0, z0, rd);
		ahb(1, BZW_IDX_IOZ, 0, rd);
		u_cpu.access(1, 16'h1234, 0, n, z, w, wo, ao);
		chk("long write", n, cycles(0, 1));
		pz = 0;
		pp = 0;
		for (int i = 0; i < 40; i++) begin
			z0 = $random(seed) & 32'hFF9F;
			io = $random(seed);
			bif = $random(seed);
			ahb(1, BZW_IDX_ZONE0, z0, rd);
			ahb(1, BZW_IDX_IOZ, io, rd);
			ahb(1, BZW_IDX_BIF, bif, rd);
			z0 = z0 & 32'h0EFF;
			io = (io & 32'h029F) | 32'h0400;
			bif = bif & 32'h7;
			ahb(0, BZW_IDX_ZONE0, 0, rd); chk("zone0", rd, z0);
			ahb(0, BZW_IDX_IOZ, 0, rd); chk("io", rd, io);
			ahb(0, BZW_IDX_BIF, 0, rd); chk("bif", rd, bif);
			r = $random(seed);
			eeprom_fast_access <= r[0];
			// new words take effect on the very next cycle
			for (int j = 0; j < 6; j++) begin
				r = $random(seed);
				k = r[18:16] % 5;
				a = base[k] | (r[15:0] & msk[k]);
				u_cpu.access(r[20], a, r[22:21], n, z, w, wo, ao);
				chk("cycles", n, cycles(k, r[20]));
				chk("zone", z, k);
				chk("write", wo, r[20]);
				chk("addr", ao, a);
				if (k == 0 || k == 4) chk("width", w, k == 4 ? io[7] : z0[7]);
				pz = k;
				pp = k == 4 ? io[9] : z0[9];
				// status: idle phase, zone of the finished cycle, one cycle seen
				ahb(0, BZW_IDX_STATUS, 0, rd);
				chk("status", rd, 32'h0000_0100 | (k << 3));
			end
		end
		finish_test();
	end
endmodule
